// ===== core/barrier_ctl_pkg.sv
// Package for the isolation barrier control block.
// Holds register offsets, field positions, default identity and timing.
package barrier_ctl_pkg;
  // Register word indices (printed offsets are indices, byte addr = 4*idx)
  localparam logic [7:0] IDX_POWER    = 8'h02;
  localparam logic [7:0] IDX_LOCK     = 8'h03;
  localparam logic [7:0] IDX_POLL     = 8'h05;
  localparam logic [7:0] IDX_HOSTST   = 8'h0d;
  localparam logic [7:0] IDX_TIMER    = 8'h15;
  localparam logic [7:0] IDX_IDENT    = 8'h1d;
  localparam logic [7:0] IDX_LINEST   = 8'h1e;
  localparam logic [7:0] IDX_LOOP     = 8'h20;
  // Field positions
  localparam int POS_LINE_PWR  = 2;
  localparam int POS_LVD_EN    = 3;
  localparam int POS_SYNC_LOSS = 1;
  localparam int POS_AUTO_POLL = 3;
  localparam int POS_IRQ_EN    = 1;
  localparam int POS_HOST_LOST = 6;
  localparam int POS_IDLE_DIS  = 6;
  localparam int POS_LINE_LOST = 2;
  localparam int POS_AC_EN     = 0;
  localparam int POS_DC_EN     = 1;
  localparam int POS_DCIV_LO   = 2;
  localparam int POS_IDENT_LO  = 4;
  // Identity stored when a poll answers zero; value is arbitrary
  localparam logic [3:0] IDENT_DEFAULT = 4'h5;
  // Timing: no-transition window
  localparam int IDLE_TIME_US = 400;
  localparam int CLK_MHZ      = 200;
  localparam int IDLE_CYCLES  = IDLE_TIME_US * CLK_MHZ;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Line loop operating mode
  typedef enum logic [2:0] {
    LOOP_OFF   = 3'b001,
    LOOP_HOLD  = 3'b010,
    LOOP_SEIZE = 3'b100
  } loop_mode_t;
  // Poll sequencer states
  typedef enum logic [2:0] {
    PS_WAIT = 3'b001,
    PS_REQ  = 3'b010,
    PS_DONE = 3'b100
  } poll_state_t;
  // Line-side control bundle
  typedef struct packed {
    logic       line_power_select;
    logic       ac_loop_enable;
    logic       dc_loop_enable;
    logic [1:0] dc_iv_select;
  } line_ctl_t;
endpackage

// ===== core/barrier_ctl.sv
// Isolation barrier control, lock-loss reporting and fail-safe hook logic.
// Assumes an AXI4-Lite master on clk_i and barrier link status inputs
// synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] Power select: 0 barrier, 1 line powered
// [R2] Return to barrier power needs level-detect off
// [R3] Sync-loss flag set on loss, cleared by read
// [R4] Sync-loss flag is a maskable interrupt source
// [R5] Sync-loss interrupt enable resets to one
// [R6] Auto-poll identity after lock when enabled
// [R7] Lock loss zeroes stored identity
// [R8] Host lock-lost flag resets one, rearms
// [R9] Idle timer disable resets zero, 400 us
// [R10] Idle timeout resets line side, on hook
// [R11] Line lock-lost zero keeps transmit requests going while host is unlocked
// [R12] Line lock-lost reads one on header loss
// [R13] Line power stops barrier power delivery
// [R14] Both loop enables give hold mode
// [R15] DC only gives seize mode
// [R16] Power-on reset forces on hook
// [R17] Low line supply forces on hook
// [R18] Loss flag restarts barrier synchronisation
// [R19] Successful poll leaves nonzero identity
// [R20] Interrupt follows flag and enable
// [R21] Read clears flag, same-cycle loss wins
module barrier_ctl
  import barrier_ctl_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES  // No-transition timeout cycles
) (
  input  wire logic        clk_i,           // 200 MHz clock
  input  wire logic        rstn_i,          // Async reset, low
  input  wire logic        ce_i,            // Clock enable
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr_i,      // Write address
  input  wire logic        s_awvalid_i,     // Write address valid
  output logic             s_awready_o,     // Write address ready
  input  wire logic [31:0] s_wdata_i,       // Write data
  input  wire logic [3:0]  s_wstrb_i,       // Write strobes
  input  wire logic        s_wvalid_i,      // Write data valid
  output logic             s_wready_o,      // Write data ready
  output logic [1:0]       s_bresp_o,       // Write response
  output logic             s_bvalid_o,      // Write response valid
  input  wire logic        s_bready_i,      // Write response ready
  input  wire logic [7:0]  s_araddr_i,      // Read address
  input  wire logic        s_arvalid_i,     // Read address valid
  output logic             s_arready_o,     // Read address ready
  output logic [31:0]      s_rdata_o,       // Read data
  output logic [1:0]       s_rresp_o,       // Read response
  output logic             s_rvalid_o,      // Read data valid
  input  wire logic        s_rready_i,      // Read data ready
  // Barrier link
  input  wire logic        host_locked_i,   // Host side barrier in sync
  input  wire logic        header_loss_i,   // Line side header loss
  input  wire logic        transition_i,    // Barrier edge seen
  input  wire logic        supply_low_i,    // Line supply under level
  input  wire logic        off_hook_req_i,  // Requested off-hook
  input  wire logic        ident_valid_i,   // Poll answer arrived
  input  wire logic [3:0]  ident_i,         // Polled identity
  output logic             poll_req_o,      // Identity poll request
  output logic             resync_o,        // Restart sync sequence
  output logic             tx_request_o,    // Transmit request strobe
  output logic             barrier_pwr_o,   // Power across barrier
  output logic             line_reset_o,    // Line side self reset
  output logic             off_hook_o,      // Hook state, 1 off hook
  output line_ctl_t        line_ctl_o,      // Line loop controls
  output loop_mode_t       loop_mode_o,     // Hold / seize decode
  output logic             irq_o            // Sync loss interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic        line_pwr_r;      // Line powered mode
  logic        lvd_en_r;        // Level detect enable
  logic        sync_loss_r;     // Clear-on-read loss flag
  logic        auto_poll_r;     // Auto poll enable
  logic        irq_en_r;        // Loss interrupt enable
  logic        host_lost_r;     // Host side lock lost
  logic        idle_dis_r;      // Idle timer disable
  logic        line_lost_r;     // Line side lock lost
  logic [3:0]  ident_r;         // Stored identity
  logic        ac_en_r;         // AC loop enable
  logic        dc_en_r;         // DC loop enable
  logic [1:0]  dciv_r;          // DC-IV select
  logic        locked_q;        // Previous lock level
  logic [31:0] idle_cnt_r;      // No-transition counter
  logic        hook_r;          // Off-hook state
  logic        por_r;           // First cycle after reset
  poll_state_t poll_r;          // Poll sequencer

  logic        loss_evt;        // Lock dropped this cycle
  logic        idle_trip;       // Timer expired
  logic        wr_go;           // Write taken
  logic        rd_go;           // Read taken
  logic [7:0]  widx;            // Write register index
  logic [7:0]  ridx;            // Read register index
  logic [31:0] rd_val;          // Read mux
  logic        rd_hit;          // Read address mapped
  logic        wr_hit;          // Write address mapped

  assign loss_evt = locked_q & ~host_locked_i;
  assign widx     = {2'b00, s_awaddr_i[7:2]};
  assign ridx     = {2'b00, s_araddr_i[7:2]};

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake: address and data accepted together
  // Ready only while enabled: a frozen block must not accept and drop
  assign s_awready_o = s_awvalid_i & s_wvalid_i & ~s_bvalid_o & ce_i;
  assign s_wready_o  = s_awready_o;
  assign s_arready_o = s_arvalid_i & ~s_rvalid_o & ce_i;
  assign wr_go       = s_awready_o;
  assign rd_go       = s_arready_o;
  assign wr_hit = (widx == IDX_POWER) | (widx == IDX_POLL) |
                  (widx == IDX_TIMER) | (widx == IDX_LINEST) |
                  (widx == IDX_LOOP);

  // Write response channel
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_bvalid_o <= 1'b0;
      s_bresp_o  <= RESP_OKAY;
    end else if (ce_i) begin
      if (wr_go) begin
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ridx)
      IDX_POWER: begin
        rd_val[POS_LINE_PWR] = line_pwr_r;
        rd_val[POS_LVD_EN]   = lvd_en_r;
      end
      IDX_LOCK:   rd_val[POS_SYNC_LOSS] = sync_loss_r;
      IDX_POLL: begin
        rd_val[POS_AUTO_POLL] = auto_poll_r;
        rd_val[POS_IRQ_EN]    = irq_en_r;
      end
      IDX_HOSTST: rd_val[POS_HOST_LOST] = host_lost_r;
      IDX_TIMER:  rd_val[POS_IDLE_DIS]  = idle_dis_r;
      IDX_IDENT:  rd_val[POS_IDENT_LO+:4] = ident_r;
      IDX_LINEST: rd_val[POS_LINE_LOST] = line_lost_r;
      IDX_LOOP: begin
        rd_val[POS_AC_EN]     = ac_en_r;
        rd_val[POS_DC_EN]     = dc_en_r;
        rd_val[POS_DCIV_LO+:2] = dciv_r;
      end
      default:    rd_hit = 1'b0;
    endcase
  end

  // Read data channel, data from flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o  <= 32'h0000_0000;
      s_rresp_o  <= RESP_OKAY;
    end else if (ce_i) begin
      if (rd_go) begin
        s_rvalid_o <= 1'b1;
        s_rdata_o  <= rd_val;
        s_rresp_o  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-written control bits (low byte lane only)
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_pwr_r  <= 1'b0;                   // see [R1]
      lvd_en_r    <= 1'b0;
      auto_poll_r <= 1'b1;                   // see [R6]
      irq_en_r    <= 1'b1;                   // see [R5]
      idle_dis_r  <= 1'b0;                   // see [R9]
      ac_en_r     <= 1'b0;
      dc_en_r     <= 1'b0;
      dciv_r      <= 2'b00;
    end else if (ce_i && wr_go && s_wstrb_i[0]) begin
      case (widx)
        IDX_POWER: begin
          lvd_en_r <= s_wdata_i[POS_LVD_EN];
          // Back to barrier power only with level detect off; see [R2]
          if (s_wdata_i[POS_LINE_PWR] || !lvd_en_r)
            line_pwr_r <= s_wdata_i[POS_LINE_PWR];  // see [R1]
        end
        IDX_POLL: begin
          auto_poll_r <= s_wdata_i[POS_AUTO_POLL];
          irq_en_r    <= s_wdata_i[POS_IRQ_EN];     // see [R5]
        end
        IDX_TIMER: idle_dis_r <= s_wdata_i[POS_IDLE_DIS];  // see [R9]
        IDX_LOOP: begin
          ac_en_r <= s_wdata_i[POS_AC_EN];
          dc_en_r <= s_wdata_i[POS_DC_EN];
          dciv_r  <= s_wdata_i[POS_DCIV_LO+:2];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock tracking, clear-on-read and write-to-clear flags; set beats clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      locked_q    <= 1'b0;
      sync_loss_r <= 1'b0;
      host_lost_r <= 1'b1;                   // see [R8]
      line_lost_r <= 1'b0;
    end else if (ce_i) begin
      locked_q <= host_locked_i;
      // Loss event sets, read clears; see [R3] [R21]
      if (loss_evt)
        sync_loss_r <= 1'b1;
      else if (rd_go && ridx == IDX_LOCK)
        sync_loss_r <= 1'b0;
      // Rearms while still unlocked; see [R8]
      if (!host_locked_i)
        host_lost_r <= 1'b1;
      else if (rd_go && ridx == IDX_HOSTST)
        host_lost_r <= 1'b0;
      // Header loss sets; software write of zero clears; see [R12]
      if (header_loss_i)
        line_lost_r <= 1'b1;
      else if (wr_go && s_wstrb_i[0] && widx == IDX_LINEST)
        line_lost_r <= s_wdata_i[POS_LINE_LOST];
    end
  end

  // Restart sync once the loss flag is up; see [R18]
  assign resync_o = sync_loss_r & ~host_locked_i;
  // Keep requesting transfers while line lock-lost bit is 0 and host is unlocked; see [R11]
  assign tx_request_o = ~line_lost_r & ~host_locked_i;
  // Interrupt gated by enable; see [R4] [R20]
  assign irq_o = sync_loss_r & irq_en_r;

  ////////////////////////////////////////////////////////////////////////
  // Identity poll sequencer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      poll_r  <= PS_WAIT;
      ident_r <= 4'h0;
    end else if (ce_i) begin
      if (!host_locked_i) begin
        poll_r  <= PS_WAIT;
        ident_r <= 4'h0;                     // see [R7]
      end else begin
        case (poll_r)
          PS_WAIT: if (auto_poll_r) poll_r <= PS_REQ;   // see [R6]
          PS_REQ: if (ident_valid_i) begin
            poll_r  <= PS_DONE;
            // Zero answer still stored nonzero marker; see [R19]
            ident_r <= (ident_i != 4'h0) ? ident_i : IDENT_DEFAULT;
          end
          PS_DONE: ;
          default: poll_r <= PS_WAIT;
        endcase
      end
    end
  end
  assign poll_req_o = (poll_r == PS_REQ);

  ////////////////////////////////////////////////////////////////////////
  // No-transition timer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt_r <= 32'h0000_0000;
    end else if (ce_i) begin
      if (idle_dis_r || transition_i || idle_trip)
        idle_cnt_r <= 32'h0000_0000;
      else
        idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
    end
  end
  assign idle_trip = !idle_dis_r &&
                     (idle_cnt_r == 32'(IDLE_LIMIT - 1));  // see [R10]
  assign line_reset_o = idle_trip;

  ////////////////////////////////////////////////////////////////////////
  // Hook state with fail-safe on-hook forcing
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hook_r <= 1'b0;                        // see [R16]
      por_r  <= 1'b1;
    end else if (ce_i) begin
      por_r <= 1'b0;
      if (por_r || idle_trip || supply_low_i)  // see [R10] [R16] [R17]
        hook_r <= 1'b0;
      else
        hook_r <= off_hook_req_i;
    end
  end
  assign off_hook_o = hook_r;

  // Line power stops barrier power; see [R13]
  assign barrier_pwr_o = ~line_pwr_r;
  assign line_ctl_o = '{line_power_select: line_pwr_r,
                        ac_loop_enable:    ac_en_r,
                        dc_loop_enable:    dc_en_r,
                        dc_iv_select:      dciv_r};

  // Loop mode decode; see [R14] [R15]
  always_comb begin
    if (dc_en_r && ac_en_r)
      loop_mode_o = LOOP_HOLD;
    else if (dc_en_r)
      loop_mode_o = LOOP_SEIZE;
    else
      loop_mode_o = LOOP_OFF;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_loss_sets_flag: assert property ( // see [R3] [R21]
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && loss_evt |=> sync_loss_r)
    else $error("loss event did not set flag");
  a_read_clears: assert property ( // see [R3]
    @(posedge clk_i) disable iff (!rstn_i)
    rd_go && ridx == IDX_LOCK && !loss_evt |=> !sync_loss_r)
    else $error("read did not clear loss flag");
  a_irq_gate: assert property ( // see [R4] [R20]
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && loss_evt |=> irq_o == irq_en_r)
    else $error("irq mismatch");
  a_ident_zero: assert property ( // see [R7]
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && !host_locked_i |=> ident_r == 4'h0)
    else $error("identity not cleared on loss");
  a_poll_off: assert property ( // see [R6]
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && !auto_poll_r && poll_r == PS_WAIT |=> !poll_req_o)
    else $error("poll issued while disabled");
  a_host_rearm: assert property ( // see [R8]
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && !host_locked_i |=> host_lost_r)
    else $error("host lost flag not rearmed");
  a_idle_hook: assert property ( // see [R10]
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && idle_trip |=> !off_hook_o)
    else $error("idle timeout left line off hook");
  a_supply_hook: assert property ( // see [R17]
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && supply_low_i |=> !off_hook_o)
    else $error("low supply left line off hook");
  a_power_back: assert property ( // see [R2]
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && lvd_en_r && line_pwr_r |=> line_pwr_r)
    else $error("barrier power taken with level detect on");
  a_seize_mode: assert property ( // see [R15]
    @(posedge clk_i) disable iff (!rstn_i)
    dc_en_r && !ac_en_r |-> loop_mode_o == LOOP_SEIZE)
    else $error("seize mode decode wrong");

endmodule
`default_nettype wire

// ===== testbench/line_side_model.sv
// Behavioural model of the line-side device across the barrier.
// Assumes the bench steers lock, edges and header loss by its inputs.
`timescale 1ns/1ps
`default_nettype none
module line_side_model #(
  parameter logic [3:0] ID = 4'ha     // Arbitrary identity value
) (
  input  wire logic       clk_i,      // Clock
  input  wire logic       rstn_i,     // Reset, low
  input  wire logic       lock_i,     // Bench: link in sync
  input  wire logic       quiet_i,    // Bench: stop barrier edges
  input  wire logic       hdr_i,      // Bench: header loss
  input  wire logic [3:0] dly_i,      // Bench: poll answer delay
  input  wire logic       poll_i,     // Poll request from block
  output logic            locked_o,   // Host side in sync
  output logic            edge_o,     // Barrier transition
  output logic            hdr_loss_o, // Header loss seen
  output logic            id_vld_o,   // Identity answer strobe
  output logic [3:0]      id_o        // Identity, junk when idle
);
  logic [3:0] wait_r;                 // Answer delay count
  ////////////////////////////////////////////////////////////////
  // Link state; edges stand still when quiet
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      locked_o   <= 1'b0;
      edge_o     <= 1'b0;
      hdr_loss_o <= 1'b0;
    end else begin
      locked_o   <= lock_i;
      hdr_loss_o <= hdr_i;
      edge_o     <= quiet_i ? 1'b0 : ~edge_o;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Identity answer, zero on long delays; idle data toggles
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_r   <= 4'h0;
      id_vld_o <= 1'b0;
      id_o     <= 4'h0;
    end else if (poll_i && !id_vld_o && locked_o) begin
      if (wait_r == dly_i) begin
        id_vld_o <= 1'b1;
        id_o     <= dly_i[3] ? 4'h0 : ID;
        wait_r   <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
        id_o   <= ~id_o;
      end
    end else begin
      id_vld_o <= 1'b0;
      wait_r   <= 4'h0;
      id_o     <= ~id_o;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the barrier control block.
// Assumes the line-side model on the link, AXI4-Lite master here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import barrier_ctl_pkg::*;
  localparam int LIM = 20;            // Short idle timeout for sim
  logic clk_i, rstn_i, ce_i;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  logic locked, hdr_loss, edge_s, supply_low, hook_req, id_vld;
  logic [3:0] id_v, dly, strb;
  logic poll_req, resync, tx_req, bpwr, line_rst, off_hook, irq;
  logic lock_cmd, quiet, hdr_cmd;
  line_ctl_t lctl;
  loop_mode_t lmode;
  int err_total, samples_checked, cyc, n;
  barrier_ctl #(.IDLE_LIMIT(LIM)) i_dut (.clk_i(clk_i),
    .rstn_i(rstn_i), .ce_i(ce_i), .s_awaddr_i(awaddr),
    .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata),
    .s_wstrb_i(strb), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
    .s_rready_i(rready), .host_locked_i(locked),
    .header_loss_i(hdr_loss), .transition_i(edge_s),
    .supply_low_i(supply_low), .off_hook_req_i(hook_req),
    .ident_valid_i(id_vld), .ident_i(id_v), .poll_req_o(poll_req),
    .resync_o(resync), .tx_request_o(tx_req), .barrier_pwr_o(bpwr),
    .line_reset_o(line_rst), .off_hook_o(off_hook), .line_ctl_o(lctl),
    .loop_mode_o(lmode), .irq_o(irq));
  line_side_model i_far (.clk_i(clk_i), .rstn_i(rstn_i),
    .lock_i(lock_cmd), .quiet_i(quiet), .hdr_i(hdr_cmd), .dly_i(dly),
    .poll_i(poll_req), .locked_o(locked), .edge_o(edge_s),
    .hdr_loss_o(hdr_loss), .id_vld_o(id_vld), .id_o(id_v));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] v, e);
    samples_checked++;
    if (v !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", s, e, v);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // Write: aw and w offered together, bready held until bvalid
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    @(posedge clk_i);
    awaddr <= {i[5:0], 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk_i); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk_i); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i);
    @(posedge clk_i);
    araddr <= {i[5:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdb(input logic [7:0] i, input int b, input logic e);
    rd(i);
    chk($sformatf("reg %h bit %0d", i, b), 32'(d[b]), 32'(e));
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rdb(IDX_POWER, POS_LINE_PWR, 1'b0);
    chk("bpwr", 32'(bpwr), 32'h1);
    rdb(IDX_POLL, POS_IRQ_EN, 1'b1);
    rdb(IDX_POLL, POS_AUTO_POLL, 1'b1);
    rdb(IDX_HOSTST, POS_HOST_LOST, 1'b1);
    rdb(IDX_TIMER, POS_IDLE_DIS, 1'b0);
    rdb(IDX_LINEST, POS_LINE_LOST, 1'b0);
    chk("tx_req", 32'(tx_req), 32'h1);
    rd(8'h3f);
    chk("unmapped", 32'(r), 32'(RESP_SLVERR));
    // Lock status register refuses writes
    wr(IDX_LOCK, 32'h00000000);
    chk("ro_wr", 32'(r), 32'(RESP_SLVERR));
  endtask
  // Lock, poll answered after k cycles, identity e stored, drop lock
  task automatic t_lock(input logic [3:0] k, input logic [3:0] e);
    dly <= k;
    lock_cmd <= 1'b1;
    for (n = 0; n < 60 && !id_vld; n++) tick(1);
    tick(3);
    rd(IDX_IDENT);
    chk("ident", 32'(d[7:4]), 32'(e));
    rdb(IDX_HOSTST, POS_HOST_LOST, 1'b1);
    rdb(IDX_HOSTST, POS_HOST_LOST, 1'b0);
    lock_cmd <= 1'b0;
    tick(4);
    chk("irq", 32'(irq), 32'h1);
    chk("resync", 32'(resync), 32'h1);
    rd(IDX_IDENT);
    chk("ident0", 32'(d[7:4]), 32'h0);
    rdb(IDX_LOCK, POS_SYNC_LOSS, 1'b1);
    chk("irq_clr", 32'(irq), 32'h0);
    rdb(IDX_LOCK, POS_SYNC_LOSS, 1'b0);
  endtask
  // Masked interrupt and disabled poll
  task automatic t_mask;
    wr(IDX_POLL, 32'h00000008);
    lock_cmd <= 1'b1;
    tick(20);
    lock_cmd <= 1'b0;
    tick(4);
    chk("irq_mask", 32'(irq), 32'h0);
    rdb(IDX_LOCK, POS_SYNC_LOSS, 1'b1);
    wr(IDX_POLL, 32'h00000002);
    lock_cmd <= 1'b1;
    n = 0;
    repeat (30) begin
      tick(1);
      n += int'(poll_req);
    end
    chk("no_poll", 32'(n), 32'h0);
    lock_cmd <= 1'b0;
    wr(IDX_POLL, 32'h0000000a);
  endtask
  task automatic t_power;
    wr(IDX_POWER, 32'h00000004);
    chk("wr_ok", 32'(r), 32'(RESP_OKAY));
    chk("bpwr_off", 32'(bpwr), 32'h0);
    chk("lps", 32'(lctl.line_power_select), 32'h1);
    wr(IDX_POWER, 32'h0000000c);
    wr(IDX_POWER, 32'h00000008);
    chk("bpwr_lvd", 32'(bpwr), 32'h0);
    wr(IDX_POWER, 32'h00000004);
    wr(IDX_POWER, 32'h00000000);
    chk("bpwr_on", 32'(bpwr), 32'h1);
    // Low byte lane off: register must keep its value
    strb <= 4'he;
    wr(IDX_POWER, 32'h00000004);
    chk("strb", 32'(bpwr), 32'h1);
    strb <= 4'hf;
  endtask
  task automatic t_loop;
    logic [7:0] v[5] = '{8'h00, 8'h03, 8'h0f, 8'h02, 8'h0e};
    loop_mode_t m[5] = '{LOOP_OFF, LOOP_HOLD, LOOP_HOLD, LOOP_SEIZE,
                         LOOP_SEIZE};
    for (int k = 0; k < 5; k++) begin
      wr(IDX_LOOP, 32'(v[k]));
      chk("mode", 32'(lmode), 32'(m[k]));
      chk("dciv", 32'(lctl.dc_iv_select), 32'(v[k][3:2]));
    end
  endtask
  // Idle timer fires, then stays quiet once disabled
  task automatic t_idle;
    hook_req <= 1'b1;
    tick(4);
    chk("hook", 32'(off_hook), 32'h1);
    quiet <= 1'b1;
    for (n = 0; n < 3 * LIM && !line_rst; n++) tick(1);
    tick(1);
    // Last edge lands on time or one cycle late by parity
    chk("late", 32'(n >= LIM && n <= LIM + 1), 32'h1);
    chk("on_hook", 32'(off_hook), 32'h0);
    quiet <= 1'b0;
    wr(IDX_TIMER, 32'h00000040);
    quiet <= 1'b1;
    n = 0;
    repeat (3 * LIM) begin
      tick(1);
      n += int'(line_rst);
    end
    chk("no_idle", 32'(n), 32'h0);
    quiet <= 1'b0;
    hook_req <= 1'b0;
    wr(IDX_TIMER, 32'h00000000);
  endtask
  task automatic t_fault;
    hook_req <= 1'b1;
    tick(3);
    supply_low <= 1'b1;
    tick(3);
    chk("supply", 32'(off_hook), 32'h0);
    // Clock enable low freezes the hook state
    ce_i <= 1'b0;
    supply_low <= 1'b0;
    tick(3);
    chk("ce_hold", 32'(off_hook), 32'h0);
    ce_i <= 1'b1;
    tick(3);
    chk("ce_run", 32'(off_hook), 32'h1);
    hdr_cmd <= 1'b1;
    tick(1);
    hdr_cmd <= 1'b0;
    rdb(IDX_LINEST, POS_LINE_LOST, 1'b1);
    chk("tx_stop", 32'(tx_req), 32'h0);
    wr(IDX_LINEST, 32'h00000000);
    chk("tx_go", 32'(tx_req), 32'h1);
    tick(3);
    rstn_i <= 1'b0;
    tick(3);
    rstn_i <= 1'b1;
    tick(2);
    chk("por", 32'(off_hook), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {ce_i, rstn_i} = 2'b10;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    {lock_cmd, quiet, hdr_cmd, supply_low, hook_req} = 5'h00;
    dly = 4'h0;
    strb = 4'hf;
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    tick(12);
    rstn_i <= 1'b1;
    t_reset();
    t_lock(4'h0, 4'ha);
    t_lock(4'h9, IDENT_DEFAULT);
    t_mask();
    t_power();
    t_loop();
    t_idle();
    t_fault();
    test_done();
  end
endmodule
`default_nettype wire
